// file: src/data_stream_prefetch_control.sv
// Four-stream data prefetch control with APB command registers
//
// Behaviour
// - Stop-all halts cache touches on every active stream regardless of tag.
// - Load start begins load touches on tagged stream, transient hint clear.
// - Four independent streams selected by a 2-bit tag from the requester.
// - 32-bit descriptor block size in b[3:7]; zero means 32.
// - 32-bit descriptor block count in b[8:15]; zero means 256.
// - 32-bit descriptor stride in b[16:31]; zero means 32768.
// - 64-bit descriptor fields in b[35:39], b[40:47], b[48:63], same defaults.
// - Store start begins store-intent touches on tagged stream, hint clear.
// - Transient store start begins store-intent touches with hint set.
// - Single stop halts only the tagged stream, others keep running.
// - Transient load start begins load touches with hint set.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "stream_prefetch_cfg.svh"

module data_stream_prefetch_control
  import stream_prefetch_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic touch_valid,
  input wire logic touch_ready,
  output touch_t touch
);

  localparam int NS = `SPF_NUM_STREAMS;

  // -------------------------------------------------------------------------
  // APB decode
  // -------------------------------------------------------------------------
  logic [31:0] addr_lo_q;
  logic [31:0] addr_hi_q;
  logic [31:0] desc_lo_q;
  logic [31:0] desc_hi_q;
  stream_t strm_q [NS];
  logic [NS-1:0] active_q;
  logic [1:0] rr_q;
  logic touch_valid_q;
  touch_t touch_q;

  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hit_alo = paddr == `SPF_ADDR_LO_OFS;
  wire hit_ahi = paddr == `SPF_ADDR_HI_OFS;
  wire hit_dlo = paddr == `SPF_DESC_LO_OFS;
  wire hit_dhi = paddr == `SPF_DESC_HI_OFS;
  wire hit_cmd = paddr == `SPF_CMD_OFS;
  wire hit_sts = paddr == `SPF_STATUS_OFS;
  wire mapped = hit_alo | hit_ahi | hit_dlo | hit_dhi | hit_cmd | hit_sts;

  wire [2:0] op_raw = pwdata[`SPF_CMD_OP_MSB:`SPF_CMD_OP_LSB];
  wire [1:0] cmd_tag = pwdata[`SPF_CMD_TAG_MSB:`SPF_CMD_TAG_LSB];
  wire cmd_fmt64 = pwdata[`SPF_CMD_FMT64_BIT];
  wire op_legal = op_raw <= 3'(OP_STORE_TRANS);
  wire cmd_wr = wr & hit_cmd & op_legal;
  wire spf_op_t cmd_op = cmd_wr ? spf_op_t'(op_raw) : OP_NONE;

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  // Unmapped addresses, writes to status and illegal opcodes are refused
  assign pslverr = acc & (~mapped | (pwrite & hit_sts) |
                          (pwrite & hit_cmd & ~op_legal));
  // Read data comes from a flop loaded at the end of the setup cycle, so it
  // is zero outside the access phase; status shows the setup-cycle state
  wire rd_setup = psel & ~penable & ~pwrite;
  wire [31:0] rdata_d = hit_alo ? addr_lo_q :
                        hit_ahi ? addr_hi_q :
                        hit_dlo ? desc_lo_q :
                        hit_dhi ? desc_hi_q :
                        hit_sts ? {28'h000_0000, active_q} :
                        32'h0000_0000;
  logic [31:0] prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= rd_setup ? rdata_d : 32'h0000_0000;
    end
  end

  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_lo_q <= 32'h0000_0000;
      addr_hi_q <= 32'h0000_0000;
      desc_lo_q <= 32'h0000_0000;
      desc_hi_q <= 32'h0000_0000;
    end else begin
      if (wr & hit_alo) addr_lo_q <= pwdata;
      if (wr & hit_ahi) addr_hi_q <= pwdata;
      if (wr & hit_dlo) desc_lo_q <= pwdata;
      if (wr & hit_dhi) desc_hi_q <= pwdata;
    end
  end

  // -------------------------------------------------------------------------
  // Descriptor decode
  // -------------------------------------------------------------------------
  wire [63:0] desc64 = {desc_hi_q, desc_lo_q};
  wire [4:0] f_size = cmd_fmt64 ?
    desc64[`SPF_D64_SIZE_MSB:`SPF_D64_SIZE_LSB] :
    desc_lo_q[`SPF_D32_SIZE_MSB:`SPF_D32_SIZE_LSB];
  wire [7:0] f_cnt = cmd_fmt64 ?
    desc64[`SPF_D64_CNT_MSB:`SPF_D64_CNT_LSB] :
    desc_lo_q[`SPF_D32_CNT_MSB:`SPF_D32_CNT_LSB];
  wire [15:0] f_stride = cmd_fmt64 ?
    desc64[`SPF_D64_STRIDE_MSB:`SPF_D64_STRIDE_LSB] :
    desc_lo_q[`SPF_D32_STRIDE_MSB:`SPF_D32_STRIDE_LSB];

  wire [5:0] eff_size = (f_size == 5'h00) ? `SPF_DEF_SIZE :
                        {1'b0, f_size};
  wire [8:0] eff_cnt = (f_cnt == 8'h00) ? `SPF_DEF_COUNT :
                       {1'b0, f_cnt};
  wire [16:0] eff_stride = (f_stride == 16'h0000) ? `SPF_DEF_STRIDE :
                           {1'b0, f_stride};

  wire is_start = (cmd_op == OP_LOAD) | (cmd_op == OP_LOAD_TRANS) |
                  (cmd_op == OP_STORE) | (cmd_op == OP_STORE_TRANS);
  wire start_store = (cmd_op == OP_STORE) |
                     (cmd_op == OP_STORE_TRANS);
  wire start_trans = (cmd_op == OP_LOAD_TRANS) |
                     (cmd_op == OP_STORE_TRANS);

  stream_t new_strm;
  assign new_strm = '{addr: {addr_hi_q, addr_lo_q}, size: eff_size,
                      left: eff_cnt, stride: eff_stride,
                      store: start_store, transient: start_trans};

  // -------------------------------------------------------------------------
  // Round-robin pick among active streams
  // -------------------------------------------------------------------------
  logic [1:0] pick;
  logic pick_any;
  logic [1:0] cand;

  always_comb begin
    pick = 2'b00;
    pick_any = 1'b0;
    cand = 2'b00;
    for (int i = NS - 1; i >= 0; i--) begin
      cand = rr_q + 2'(i);
      if (active_q[cand]) begin
        pick = cand;
        pick_any = 1'b1;
      end
    end
  end

  // Issue slot is free when empty or its touch is being taken this cycle
  wire slot_free = ~touch_valid_q | touch_ready;
  // A command in the same cycle owns the stream; the issue waits a cycle
  wire load_slot = slot_free & pick_any & ~cmd_wr;

  // -------------------------------------------------------------------------
  // Per-stream state
  // -------------------------------------------------------------------------
  for (genvar s = 0; s < NS; s++) begin : g_strm
    wire sel_tag = cmd_tag == 2'(s);
    wire do_start = is_start & sel_tag;
    wire do_stop = (cmd_op == OP_STOP_ALL) |
                   ((cmd_op == OP_STOP) & sel_tag);
    wire do_step = load_slot & (pick == 2'(s));

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        active_q[s] <= 1'b0;
        strm_q[s] <= '0;
      end else if (do_start) begin
        active_q[s] <= 1'b1;
        strm_q[s] <= new_strm;
      end else if (do_stop) begin
        active_q[s] <= 1'b0;
      end else if (do_step) begin
        strm_q[s].addr <= strm_q[s].addr + 64'(strm_q[s].stride);
        strm_q[s].left <= strm_q[s].left - 9'h001;
        if (strm_q[s].left == 9'h001) active_q[s] <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Touch issue register
  // -------------------------------------------------------------------------
  // A latched touch of a stream that is stopped or restarted is withdrawn
  wire kill_slot = touch_valid_q &
                   ((cmd_op == OP_STOP_ALL) |
                    ((cmd_op == OP_STOP) | is_start) &
                    (cmd_tag == touch_q.tag));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      touch_valid_q <= 1'b0;
      touch_q <= '0;
      rr_q <= 2'b00;
    end else if (kill_slot) begin
      touch_valid_q <= 1'b0;
    end else if (load_slot) begin
      touch_valid_q <= 1'b1;
      touch_q <= '{addr: strm_q[pick].addr, size: strm_q[pick].size,
                   tag: pick, store: strm_q[pick].store,
                   transient: strm_q[pick].transient};
      rr_q <= pick + 2'b01;
    end else if (touch_ready) begin
      touch_valid_q <= 1'b0;
    end
  end

  assign touch_valid = touch_valid_q;
  assign touch = touch_q;

endmodule // data_stream_prefetch_control

// file: src/stream_prefetch_cfg.svh
// Offsets, field positions, defaults and limits of the stream prefetch control
`ifndef STREAM_PREFETCH_CFG_SVH
`define STREAM_PREFETCH_CFG_SVH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define SPF_ADDR_LO_OFS 12'h000
`define SPF_ADDR_HI_OFS 12'h004
`define SPF_DESC_LO_OFS 12'h008
`define SPF_DESC_HI_OFS 12'h00c
`define SPF_CMD_OFS 12'h010
`define SPF_STATUS_OFS 12'h014

// ---------------------------------------------------------------------------
// Command register fields
// ---------------------------------------------------------------------------
`define SPF_CMD_OP_MSB 2
`define SPF_CMD_OP_LSB 0
`define SPF_CMD_TAG_MSB 5
`define SPF_CMD_TAG_LSB 4
`define SPF_CMD_FMT64_BIT 8

// ---------------------------------------------------------------------------
// Descriptor fields, bit 0 = least significant
// ---------------------------------------------------------------------------
`define SPF_D32_SIZE_MSB 28
`define SPF_D32_SIZE_LSB 24
`define SPF_D32_CNT_MSB 23
`define SPF_D32_CNT_LSB 16
`define SPF_D32_STRIDE_MSB 15
`define SPF_D32_STRIDE_LSB 0
`define SPF_D64_SIZE_MSB 28
`define SPF_D64_SIZE_LSB 24
`define SPF_D64_CNT_MSB 23
`define SPF_D64_CNT_LSB 16
`define SPF_D64_STRIDE_MSB 15
`define SPF_D64_STRIDE_LSB 0

// ---------------------------------------------------------------------------
// Zero-field defaults and stream count
// ---------------------------------------------------------------------------
`define SPF_DEF_SIZE 6'h20
`define SPF_DEF_COUNT 9'h100
`define SPF_DEF_STRIDE 17'h08000
`define SPF_NUM_STREAMS 4

`endif

// file: src/stream_prefetch_pkg.sv
// Types shared by the stream prefetch control and its bench
package stream_prefetch_pkg;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_STOP = 3'b001,
    OP_STOP_ALL = 3'b010,
    OP_LOAD = 3'b011,
    OP_LOAD_TRANS = 3'b100,
    OP_STORE = 3'b101,
    OP_STORE_TRANS = 3'b110
  } spf_op_t;

  typedef struct packed {
    logic [63:0] addr;
    logic [5:0] size;
    logic [1:0] tag;
    logic store;
    logic transient;
  } touch_t;

  typedef struct packed {
    logic [63:0] addr;
    logic [5:0] size;
    logic [8:0] left;
    logic [16:0] stride;
    logic store;
    logic transient;
  } stream_t;

endpackage

// file: tb/spf_checker_assertions.sv
// Port checker for the stream prefetch control, bound to its top module
`timescale 1ns/10ps
module spf_checker
  import stream_prefetch_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic touch_valid,
  input wire logic touch_ready,
  input wire touch_t touch
);
  // ---------------------------------------------------------------
  // Port relations
  // ---------------------------------------------------------------
  wire acc = psel && penable;
  wire cw = acc && pwrite && paddr == 12'h010;
  wire [2:0] op = pwdata[2:0];
  wire [1:0] tg = pwdata[5:4];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_reset_idle: assert property ($rose(presetn) |-> !touch_valid)
    else $error("touch offered right after reset");
  chk_stop_all: assert property (cw && op == 3'd2 |=> !touch_valid)
    else $error("touch kept after stop all");
  chk_stop_one: assert property (cw && op == 3'd1
    |=> !(touch_valid && touch.tag == $past(tg))) else $error("stopped tag");
  chk_start_offer: assert property (cw && op inside {[3'd3:3'd6]}
    && !touch_valid |-> ##[1:2] touch_valid) else $error("no first touch");
  // A held offer may only be withdrawn by a command write
  chk_offer_holds: assert property (touch_valid && !touch_ready && !cw
    |=> touch_valid && $stable(touch)) else $error("offer changed");
  chk_size_range: assert property (touch_valid |->
    touch.size inside {[6'd1:6'd32]}) else $error("block size out of range");
  chk_cmd_reads: assert property (acc && !pwrite && paddr == 12'h010
    |-> prdata == 32'h0 && !pslverr) else $error("cmd read");
  chk_bad_op: assert property (cw && op == 3'd7 |-> pslverr)
    else $error("bad op accepted");
  cover property (cw && op == 3'd2 && touch_valid);
  cover property (touch_valid && touch_ready && touch.store);
  cover property (touch_valid && touch_ready && touch.transient);
endmodule // spf_checker

bind data_stream_prefetch_control spf_checker spf_checker_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .touch_valid, .touch_ready, .touch);

// file: tb/tb_data_stream_prefetch_control.sv
// Self-checking bench for the stream prefetch control
`timescale 1ns/10ps
module tb_data_stream_prefetch_control
  import stream_prefetch_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, grant = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, touch_valid, touch_ready;
  touch_t touch, got;
  int n_got, n_errors = 0, n_compared = 0, k;
  always #5 pclk = ~pclk;
  data_stream_prefetch_control data_stream_prefetch_control_i (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .touch_valid, .touch_ready, .touch);
  touch_sink touch_sink_i (.pclk, .presetn, .grant, .touch_valid, .touch,
    .touch_ready, .got, .n_got);
  // ---------------------------------------------------------------
  // Compare, bus and stream tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [63:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_touch(input touch_t e);
    n_compared++;
    if (got !== e) begin
      n_errors++;
      $display("CHECK FAILED touch exp %h got %h", e, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    chk("pslverr", 64'(e), 64'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 1'b0);
    chk("read", 64'(x), 64'(r));
  endtask
  // Descriptor high word is junk: no format may take fields from it
  task automatic start(input logic [63:0] a, input logic [31:0] d,
    input logic [8:0] c);
    apb(1'b1, 12'h000, a[31:0], 1'b0);
    apb(1'b1, 12'h004, a[63:32], 1'b0);
    apb(1'b1, 12'h008, d, 1'b0);
    apb(1'b1, 12'h00c, 32'hffff_ffff, 1'b0);
    apb(1'b1, 12'h010, {23'h0, c}, 1'b0);
  endtask
  task automatic take(input touch_t e);
    k = n_got;
    grant <= 1'b1;
    @(posedge pclk);
    grant <= 1'b0;
    while (n_got == k) @(posedge pclk);
    chk_touch(e);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h014, 32'h0);
    chk("touch_valid", 64'h0, 64'(touch_valid));
    $display("reset test done");
    start(64'h1_0000_1000, 32'h0802_0040, 9'h013);
    rd(12'h014, 32'h2);
    take('{64'h1_0000_1000, 6'd8, 2'd1, 1'b0, 1'b0});
    take('{64'h1_0000_1040, 6'd8, 2'd1, 1'b0, 1'b0});
    rd(12'h014, 32'h0);
    $display("single stream test done");
    for (int i = 0; i < 3; i++) begin
      automatic logic [2:0] op = 3'(4 + i);
      automatic logic [1:0] tg = 2'(2 + i);
      start(64'h2000 + 64'(i * 256), 32'h0101_0000, {3'h0, tg, 1'b0, op});
      take('{64'h2000 + 64'(i * 256), 6'd1, tg, op != 4, op != 5});
    end
    $display("start kinds test done");
    start(64'h8000_0000, 32'h0, 9'h003);
    start(64'h9000_0000, 32'h0, 9'h023);
    rd(12'h014, 32'h5);
    take('{64'h8000_0000, 6'd32, 2'd0, 1'b0, 1'b0});
    take('{64'h9000_0000, 6'd32, 2'd2, 1'b0, 1'b0});
    take('{64'h8000_8000, 6'd32, 2'd0, 1'b0, 1'b0});
    apb(1'b1, 12'h010, 32'h1, 1'b0);
    rd(12'h014, 32'h4);
    chk("tag", 64'h2, 64'(touch.tag));
    start(64'ha000_0000, 32'h0400_0000, 9'h023);
    take('{64'ha000_0000, 6'd4, 2'd2, 1'b0, 1'b0});
    start(64'hb000_0000, 32'h0, 9'h013);
    apb(1'b1, 12'h010, 32'h2, 1'b0);
    rd(12'h014, 32'h0);
    chk("touch_valid", 64'h0, 64'(touch_valid));
    $display("stop test done");
    start(64'hc000_0000, 32'h0301_0000, 9'h103);
    take('{64'hc000_0000, 6'd3, 2'd0, 1'b0, 1'b0});
    apb(1'b0, 12'h018, 32'h0, 1'b1);
    apb(1'b1, 12'h014, 32'h1, 1'b1);
    apb(1'b1, 12'h010, 32'h7, 1'b1);
    rd(12'h010, 32'h0);
    rd(12'h014, 32'h0);
    $display("format and refusal test done");
    report_and_stop;
  end
endmodule // tb_data_stream_prefetch_control

// file: tb/touch_sink.sv
// Cache-side model that takes one offered touch per grant
`timescale 1ns/10ps
module touch_sink
  import stream_prefetch_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic grant,
  input wire logic touch_valid,
  input wire touch_t touch,
  output logic touch_ready,
  output touch_t got,
  output int n_got
);
  logic pend_q;
  // Ready only while a grant waits, so offers stall between grants
  assign touch_ready = pend_q && touch_valid;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      got <= '0;
      n_got <= 0;
    end else if (touch_ready) begin
      pend_q <= 1'b0;
      got <= touch;
      n_got <= n_got + 1;
    end else if (grant) begin
      pend_q <= 1'b1;
    end
  end
endmodule // touch_sink
